// File: core/mixer_amp_pkg.sv
// Package with register map, field layout and reset values of the mixer bank.
package mixer_amp_pkg;

    // ********************************************************************
    // Register offsets (byte addresses on the bus).
    // ********************************************************************
    localparam logic [7:0] OFS_IN_ONE_CTRL = 8'h2C;
    localparam logic [7:0] OFS_IN_ONE_GAIN = 8'h2D;
    localparam logic [7:0] OFS_IN_TWO_CTRL = 8'h2E;
    localparam logic [7:0] OFS_IN_TWO_GAIN = 8'h2F;
    localparam logic [7:0] OFS_OUT_L_CTRL = 8'hCC;
    localparam logic [7:0] OFS_OUT_L_GAIN = 8'hCD;
    localparam logic [7:0] OFS_OUT_R_CTRL = 8'hCE;
    localparam logic [7:0] OFS_OUT_R_GAIN = 8'hCF;

    // ********************************************************************
    // Field positions.
    // ********************************************************************
    localparam int BIT_AMP_EN = 7;
    localparam int BIT_MUTE = 6;
    localparam int BIT_RAMP = 5;
    localparam int BIT_ZERO_CROSS = 4;
    localparam int BIT_MIX_SEL = 3;
    localparam int IN_GAIN_W = 4;
    localparam int OUT_GAIN_W = 2;

    // ********************************************************************
    // Reset values.
    // ********************************************************************
    localparam logic [7:0] RST_IN_CTRL = 8'h48;
    localparam logic [3:0] RST_IN_GAIN = 4'h3;
    localparam logic [7:0] RST_OUT_CTRL = 8'h00;
    localparam logic [1:0] RST_OUT_GAIN = 2'h3;
    localparam logic [7:0] IN_CTRL_MASK = 8'hF8;
    localparam logic [7:0] OUT_CTRL_MASK = 8'h80;

    // ********************************************************************
    // Ramp timing: one gain step per ramp period.
    // ********************************************************************
    localparam int CLK_HZ = 25000000;
    localparam int RAMP_STEP_US = 10;
    localparam int RAMP_STEP_CYC = CLK_HZ / 1000000 * RAMP_STEP_US;

endpackage

// File: core/gain_apply_if.sv
// Interface joining the register bank to one gain applier.
`timescale 1ns/1ns
`default_nettype none
interface gain_apply_if;
    logic [3:0] target;
    logic ramp_en;
    logic zero_cross_en;
    logic [3:0] applied;
    logic busy;
    modport bank (output target, output ramp_en, output zero_cross_en,
                  input applied, input busy);
    modport unit (input target, input ramp_en, input zero_cross_en,
                  output applied, output busy);
endinterface
`default_nettype wire

// File: core/gain_applier.sv
// Gain applier: instant, zero-cross or ramped update of one gain code.
`timescale 1ns/1ns
`default_nettype none
module gain_applier #(
    parameter int STEP_CYC = mixer_amp_pkg::RAMP_STEP_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Signal zero crossing and ramp tick
    input wire logic zero_cross_i,
    input wire logic tick_i,
    // Bank side
    gain_apply_if.unit g
);
    typedef struct packed {
        logic [3:0] applied;
    } st_t;
    st_t s, next_s;

    always_comb begin
        next_s = s;
        if (s.applied != g.target) begin
            if (g.ramp_en) begin
                if (tick_i) begin
                    if (g.target > s.applied) begin
                        next_s.applied = s.applied + 4'h1;
                    end else begin
                        next_s.applied = s.applied - 4'h1;
                    end
                end
            end else if (g.zero_cross_en) begin
                if (zero_cross_i) begin
                    next_s.applied = g.target;
                end
            end else begin
                next_s.applied = g.target;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{applied: mixer_amp_pkg::RST_IN_GAIN};
        end else begin
            s <= next_s;
        end
    end

    assign g.applied = s.applied;
    assign g.busy = (s.applied != g.target);

    chk_ramp_single_step: assert property (@(posedge clk_i)
        disable iff (rst_i)
        g.ramp_en && tick_i && g.busy |=> ($past(s.applied) - s.applied == 4'h1
        || s.applied - $past(s.applied) == 4'h1))
        else $error("ramp moved more than one step");
    chk_zc_holds_gain: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !g.ramp_en && g.zero_cross_en && !zero_cross_i |=> $stable(s.applied))
        else $error("zero-cross gain changed without crossing");
    chk_instant_update: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !g.ramp_en && !g.zero_cross_en |=> s.applied == $past(g.target))
        else $error("instant gain update missed");
    cov_ramp_done: cover property (@(posedge clk_i) disable iff (rst_i)
        g.ramp_en && g.busy ##1 !g.busy);
endmodule // gain_applier
`default_nettype wire

// File: core/mixer_amp_regs.sv
// Mixer amplifier control register bank with a classic Wishbone slave.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module mixer_amp_regs #(
    parameter int RAMP_CYC = mixer_amp_pkg::RAMP_STEP_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Analogue zero-crossing flags, one per input amplifier
    input wire logic in_one_zero_cross_i,
    input wire logic in_two_zero_cross_i,
    // Input mixer amplifier controls
    output logic in_one_amp_en_o,
    output logic in_one_mute_o,
    output logic in_one_mix_en_o,
    output logic [3:0] in_one_gain_o,
    output logic in_two_amp_en_o,
    output logic in_two_mute_o,
    output logic in_two_mix_en_o,
    output logic [3:0] in_two_gain_o,
    // Output mixer amplifier controls
    output logic out_left_amp_en_o,
    output logic [1:0] out_left_gain_o,
    output logic out_right_amp_en_o,
    output logic [1:0] out_right_gain_o
);

    // ********************************************************************
    // State.
    // ********************************************************************
    typedef struct packed {
        logic [7:0] in_ctrl_one;
        logic [3:0] in_gain_one;
        logic [7:0] in_ctrl_two;
        logic [3:0] in_gain_two;
        logic [7:0] out_ctrl_l;
        logic [1:0] out_gain_l;
        logic [7:0] out_ctrl_r;
        logic [1:0] out_gain_r;
        logic [15:0] tick_cnt;
        logic ack;
        logic [31:0] rdata;
    } regs_t;
    regs_t r, next_r;

    logic [3:0] applied_one;
    logic [3:0] applied_two;
    logic ramp_tick;
    logic in_two_zero_cross_on;
    logic access;

    gain_apply_if g_one();
    gain_apply_if g_two();

    // Decode used by the read path only; writes decode in the next-state logic.
    function automatic logic [7:0] read_reg(input regs_t v,
                                            input logic [7:0] a);
        case (a)
            mixer_amp_pkg::OFS_IN_ONE_CTRL: read_reg = v.in_ctrl_one;
            mixer_amp_pkg::OFS_IN_ONE_GAIN: read_reg = {4'h0, v.in_gain_one};
            mixer_amp_pkg::OFS_IN_TWO_CTRL: read_reg = v.in_ctrl_two;
            mixer_amp_pkg::OFS_IN_TWO_GAIN: read_reg = {4'h0, v.in_gain_two};
            mixer_amp_pkg::OFS_OUT_L_CTRL: read_reg = v.out_ctrl_l;
            mixer_amp_pkg::OFS_OUT_L_GAIN: read_reg = {6'h00, v.out_gain_l};
            mixer_amp_pkg::OFS_OUT_R_CTRL: read_reg = v.out_ctrl_r;
            mixer_amp_pkg::OFS_OUT_R_GAIN: read_reg = {6'h00, v.out_gain_r};
            default: read_reg = 8'h00;
        endcase
    endfunction

    assign access = cyc_i && stb_i && !r.ack;

    // ********************************************************************
    // Next-state logic.
    // ********************************************************************
    always_comb begin
        next_r = r;
        next_r.ack = access;
        next_r.rdata = 32'h0000_0000;
        if (r.tick_cnt == 16'(RAMP_CYC - 1)) begin
            next_r.tick_cnt = 16'h0000;
        end else begin
            next_r.tick_cnt = r.tick_cnt + 16'h0001;
        end
        if (access && !we_i) begin
            next_r.rdata = {24'h000000, read_reg(r, adr_i)};
        end
        // Only byte lane 0 carries register data; other lanes are ignored.
        if (access && we_i && sel_i[0]) begin
            case (adr_i)
                // same control bits as mixer two
                mixer_amp_pkg::OFS_IN_ONE_CTRL:
                    next_r.in_ctrl_one = dat_i[7:0]
                        & mixer_amp_pkg::IN_CTRL_MASK;
                mixer_amp_pkg::OFS_IN_ONE_GAIN:
                    next_r.in_gain_one = dat_i[3:0];
                // enable, mute, ramp, zero cross, mix select
                mixer_amp_pkg::OFS_IN_TWO_CTRL:
                    next_r.in_ctrl_two = dat_i[7:0]
                        & mixer_amp_pkg::IN_CTRL_MASK;
                mixer_amp_pkg::OFS_IN_TWO_GAIN:
                    next_r.in_gain_two = dat_i[3:0];
                mixer_amp_pkg::OFS_OUT_L_CTRL:
                    next_r.out_ctrl_l = dat_i[7:0]
                        & mixer_amp_pkg::OUT_CTRL_MASK;
                mixer_amp_pkg::OFS_OUT_L_GAIN:
                    next_r.out_gain_l = dat_i[1:0];
                mixer_amp_pkg::OFS_OUT_R_CTRL:
                    next_r.out_ctrl_r = dat_i[7:0]
                        & mixer_amp_pkg::OUT_CTRL_MASK;
                mixer_amp_pkg::OFS_OUT_R_GAIN:
                    next_r.out_gain_r = dat_i[1:0];
                default: begin
                end
            endcase
        end
    end

    // ********************************************************************
    // Registers.
    // ********************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '{in_ctrl_one: mixer_amp_pkg::RST_IN_CTRL,
                   in_gain_one: mixer_amp_pkg::RST_IN_GAIN,
                   in_ctrl_two: mixer_amp_pkg::RST_IN_CTRL,
                   in_gain_two: mixer_amp_pkg::RST_IN_GAIN,
                   out_ctrl_l: mixer_amp_pkg::RST_OUT_CTRL,
                   out_gain_l: mixer_amp_pkg::RST_OUT_GAIN,
                   out_ctrl_r: mixer_amp_pkg::RST_OUT_CTRL,
                   out_gain_r: mixer_amp_pkg::RST_OUT_GAIN,
                   tick_cnt: 16'h0000,
                   ack: 1'b0,
                   rdata: 32'h0000_0000};
        end else begin
            r <= next_r;
        end
    end

    // ********************************************************************
    // Gain appliers.
    // ********************************************************************
    assign ramp_tick = (r.tick_cnt == 16'(RAMP_CYC - 1));
    assign in_two_zero_cross_on = r.in_ctrl_two[mixer_amp_pkg::BIT_ZERO_CROSS];

    assign g_one.target = r.in_gain_one;
    assign g_one.ramp_en = r.in_ctrl_one[mixer_amp_pkg::BIT_RAMP];
    assign g_one.zero_cross_en = r.in_ctrl_one[mixer_amp_pkg::BIT_ZERO_CROSS];
    assign g_two.target = r.in_gain_two;
    assign g_two.ramp_en = r.in_ctrl_two[mixer_amp_pkg::BIT_RAMP];
    assign g_two.zero_cross_en = in_two_zero_cross_on;
    assign applied_one = g_one.applied;
    assign applied_two = g_two.applied;

    gain_applier #(.STEP_CYC(RAMP_CYC)) u_apply_one (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .zero_cross_i(in_one_zero_cross_i),
        .tick_i(ramp_tick),
        .g(g_one)
    );

    gain_applier #(.STEP_CYC(RAMP_CYC)) u_apply_two (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .zero_cross_i(in_two_zero_cross_i),
        .tick_i(ramp_tick),
        .g(g_two)
    );

    // ********************************************************************
    // Outputs.
    // ********************************************************************
    assign dat_o = r.rdata;
    assign ack_o = r.ack;
    assign in_one_amp_en_o = r.in_ctrl_one[mixer_amp_pkg::BIT_AMP_EN];
    assign in_one_mute_o = r.in_ctrl_one[mixer_amp_pkg::BIT_MUTE];
    assign in_one_mix_en_o = r.in_ctrl_one[mixer_amp_pkg::BIT_MIX_SEL];
    assign in_one_gain_o = applied_one;
    assign in_two_amp_en_o = r.in_ctrl_two[mixer_amp_pkg::BIT_AMP_EN];
    assign in_two_mute_o = r.in_ctrl_two[mixer_amp_pkg::BIT_MUTE];
    assign in_two_mix_en_o = r.in_ctrl_two[mixer_amp_pkg::BIT_MIX_SEL];
    assign in_two_gain_o = applied_two;
    assign out_left_amp_en_o = r.out_ctrl_l[mixer_amp_pkg::BIT_AMP_EN];
    // code 00 is stored as written; software keeps it out
    assign out_left_gain_o = r.out_gain_l;
    assign out_right_amp_en_o = r.out_ctrl_r[mixer_amp_pkg::BIT_AMP_EN];
    assign out_right_gain_o = r.out_gain_r;

    // ********************************************************************
    // Checks.
    // ********************************************************************
    // gains three after reset
    chk_gain_reset_value: assert property (@(posedge clk_i)
        $fell(rst_i) |-> r.in_gain_one == 4'h3 && r.in_gain_two == 4'h3)
        else $error("input gain reset value wrong");
    chk_mute_after_reset: assert property (@(posedge clk_i)
        $fell(rst_i) |-> in_two_mute_o && in_one_mute_o && !in_two_amp_en_o)
        else $error("input amplifier not muted after reset");
    chk_mix_reset_on: assert property (@(posedge clk_i)
        $fell(rst_i) |-> in_two_mix_en_o && in_one_mix_en_o)
        else $error("mixer stage not enabled after reset");
    chk_out_reset_off: assert property (@(posedge clk_i)
        $fell(rst_i) |-> !out_left_amp_en_o && !out_right_amp_en_o
        && out_left_gain_o == 2'h3 && out_right_gain_o == 2'h3)
        else $error("output mixer reset state wrong");
    chk_enable_write: assert property (@(posedge clk_i)
        disable iff (rst_i)
        access && we_i && sel_i[0] && adr_i == mixer_amp_pkg::OFS_IN_TWO_CTRL
        |=> in_two_amp_en_o == $past(dat_i[7]) &&
        in_two_mute_o == $past(dat_i[6]))
        else $error("control write not applied");
    chk_mix_sel_write: assert property (@(posedge clk_i)
        disable iff (rst_i)
        access && we_i && sel_i[0] && adr_i == mixer_amp_pkg::OFS_IN_TWO_CTRL
        |=> in_two_mix_en_o == $past(dat_i[3]))
        else $error("mixer stage write not applied");
    chk_ctrl_one_write: assert property (@(posedge clk_i)
        disable iff (rst_i)
        access && we_i && sel_i[0] && adr_i == mixer_amp_pkg::OFS_IN_ONE_CTRL
        |=> in_one_amp_en_o == $past(dat_i[7])
        && in_one_mute_o == $past(dat_i[6])
        && in_one_mix_en_o == $past(dat_i[3]))
        else $error("mixer one control write not applied");
    chk_in_gain_write: assert property (@(posedge clk_i)
        disable iff (rst_i)
        access && we_i && sel_i[0] && adr_i == mixer_amp_pkg::OFS_IN_TWO_GAIN
        |=> r.in_gain_two == $past(dat_i[3:0]))
        else $error("input gain write not applied");
    chk_out_en_write: assert property (@(posedge clk_i)
        disable iff (rst_i)
        access && we_i && sel_i[0] && adr_i == mixer_amp_pkg::OFS_OUT_L_CTRL
        |=> out_left_amp_en_o == $past(dat_i[7]))
        else $error("output enable write not applied");
    chk_out_gain_write: assert property (@(posedge clk_i)
        disable iff (rst_i)
        access && we_i && sel_i[0] && adr_i == mixer_amp_pkg::OFS_OUT_R_GAIN
        |=> out_right_gain_o == $past(dat_i[1:0]))
        else $error("output gain write not applied");
    chk_gain_readback: assert property (@(posedge clk_i)
        disable iff (rst_i)
        access && !we_i && adr_i == mixer_amp_pkg::OFS_IN_ONE_GAIN
        |=> ack_o && dat_o == {28'h0, r.in_gain_one})
        else $error("gain readback wrong");
    chk_ctrl_one_mask: assert property (@(posedge clk_i)
        disable iff (rst_i)
        r.in_ctrl_one[2:0] == 3'h0 && r.out_ctrl_l[6:0] == 7'h00)
        else $error("reserved control bits set");
    // Every access is answered after exactly one cycle.
    chk_ack_after_access: assert property (@(posedge clk_i)
        disable iff (rst_i)
        access |=> ack_o)
        else $error("access not acknowledged");
    chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    // Read data is zero outside the acknowledge cycle.
    chk_idle_data_zero: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data seen outside acknowledge");

    cov_write_ctrl: cover property (@(posedge clk_i) disable iff (rst_i)
        ack_o && we_i && adr_i == mixer_amp_pkg::OFS_IN_TWO_CTRL);
    cov_read_gain: cover property (@(posedge clk_i) disable iff (rst_i)
        ack_o && !we_i && adr_i == mixer_amp_pkg::OFS_OUT_L_GAIN);
    cov_zero_cross: cover property (@(posedge clk_i) disable iff (rst_i)
        in_two_zero_cross_on && in_two_zero_cross_i && g_two.busy);

endmodule // mixer_amp_regs
`default_nettype wire

// File: tb/test_mixer_amp_regs.sv
// Self-checking testbench for the mixer amplifier control register bank.
`timescale 1ns/1ns
`default_nettype none
module test_mixer_amp_regs;
    localparam int RAMP = 4;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic in_one_zero_cross_i, in_two_zero_cross_i;
    logic in_one_amp_en_o, in_one_mute_o, in_one_mix_en_o;
    logic in_two_amp_en_o, in_two_mute_o, in_two_mix_en_o;
    logic out_left_amp_en_o, out_right_amp_en_o;
    logic [3:0] in_one_gain_o, in_two_gain_o, cur, tgt, prev;
    logic [1:0] out_left_gain_o, out_right_gain_o;
    logic [31:0] q, r;
    logic [7:0] d;
    logic [7:0] addrs [8];
    logic [7:0] shadow [8];
    int error_cnt = 0;
    int comparisons = 0;
    int steps;

    mixer_amp_regs #(.RAMP_CYC(RAMP)) mixer_amp_regs_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o),
        .in_one_zero_cross_i(in_one_zero_cross_i),
        .in_two_zero_cross_i(in_two_zero_cross_i),
        .in_one_amp_en_o(in_one_amp_en_o), .in_one_mute_o(in_one_mute_o),
        .in_one_mix_en_o(in_one_mix_en_o), .in_one_gain_o(in_one_gain_o),
        .in_two_amp_en_o(in_two_amp_en_o), .in_two_mute_o(in_two_mute_o),
        .in_two_mix_en_o(in_two_mix_en_o), .in_two_gain_o(in_two_gain_o),
        .out_left_amp_en_o(out_left_amp_en_o),
        .out_left_gain_o(out_left_gain_o),
        .out_right_amp_en_o(out_right_amp_en_o),
        .out_right_gain_o(out_right_gain_o)
    );

    // ********************************************************************
    // Expectations and bus tasks.
    // ********************************************************************
    // Writable bits of each register; reserved bits read back as zero.
    function automatic logic [7:0] field_mask(input int i);
        case (i)
            0, 2: return 8'hF8;
            1, 3: return 8'h0F;
            4, 6: return 8'h80;
            default: return 8'h03;
        endcase
    endfunction

    function automatic logic [7:0] reset_val(input int i);
        case (i)
            0, 2: return 8'h48;
            4, 6: return 8'h00;
            default: return 8'h03;
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] wd, input logic [3:0] s,
                       output logic [31:0] rd);
        logic [31:0] u;
        u = $urandom();
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {u[31:8], wd};
        // Only the bench watchdog limits the wait for the answer.
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input int i, input logic [7:0] wd,
                      input logic [3:0] s);
        bus(1'b1, addrs[i], wd, s, q);
        if (s[0]) shadow[i] = wd & field_mask(i);
    endtask

    task automatic rd_chk(input int i);
        bus(1'b0, addrs[i], 8'h00, 4'hF, q);
        check($sformatf("reg_%h", addrs[i]), {24'h0, shadow[i]}, q);
    endtask

    task automatic check_pins();
        check("pins", {12'h0, shadow[0][7:6], shadow[0][3],
            shadow[1][3:0], shadow[2][7:6], shadow[2][3], shadow[3][3:0],
            shadow[4][7], shadow[5][1:0], shadow[6][7], shadow[7][1:0]},
            {12'h0, in_one_amp_en_o, in_one_mute_o, in_one_mix_en_o,
            in_one_gain_o, in_two_amp_en_o, in_two_mute_o, in_two_mix_en_o,
            in_two_gain_o, out_left_amp_en_o, out_left_gain_o,
            out_right_amp_en_o, out_right_gain_o});
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ********************************************************************
    // Clock, watchdog and test sequence.
    // ********************************************************************
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // The whole sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        wrap_up();
    end

    initial begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
        in_one_zero_cross_i = 1'b0;
        in_two_zero_cross_i = 1'b0;
        addrs = '{mixer_amp_pkg::OFS_IN_ONE_CTRL,
            mixer_amp_pkg::OFS_IN_ONE_GAIN, mixer_amp_pkg::OFS_IN_TWO_CTRL,
            mixer_amp_pkg::OFS_IN_TWO_GAIN, mixer_amp_pkg::OFS_OUT_L_CTRL,
            mixer_amp_pkg::OFS_OUT_L_GAIN, mixer_amp_pkg::OFS_OUT_R_CTRL,
            mixer_amp_pkg::OFS_OUT_R_GAIN};
        for (int i = 0; i < 8; i++) shadow[i] = reset_val(i);
        void'($urandom(32'h8872));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check_pins();
        for (int i = 0; i < 8; i++) rd_chk(i);
        // Random traffic keeps ramp and zero cross off so gains are instant.
        repeat (48) begin
            steps = $urandom_range(7);
            r = $urandom();
            d = r[7:0];
            if (steps == 0 || steps == 2) d[5:4] = 2'h0;
            // Output gain code zero is never written by software.
            if ((steps == 5 || steps == 7) && d[1:0] == 2'h0) begin
                d[1:0] = 2'h1;
            end
            wr(steps, d, {r[11:9], 1'b1});
            rd_chk(steps);
            repeat (2) @(posedge clk_i);
            check_pins();
        end
        // Lane zero disabled: the write must be dropped.
        wr(3, ~shadow[3], 4'hE);
        rd_chk(3);
        // Unmapped places read zero and keep nothing.
        foreach (addrs[k]) if (k < 2) begin
            bus(1'b1, k == 0 ? 8'h30 : 8'hCB, 8'hFF, 4'hF, q);
            bus(1'b0, k == 0 ? 8'h30 : 8'hCB, 8'h00, 4'hF, q);
            check("unmapped", 32'h0, q);
        end
        // Zero cross on input two holds the old gain until a crossing.
        wr(2, 8'h10, 4'h1);
        cur = shadow[3][3:0];
        tgt = ~cur;
        wr(3, {4'h0, tgt}, 4'h1);
        in_one_zero_cross_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        check("zc_hold", {28'h0, cur}, {28'h0, in_two_gain_o});
        in_one_zero_cross_i <= 1'b0;
        in_two_zero_cross_i <= 1'b1;
        @(posedge clk_i);
        in_two_zero_cross_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("zc_apply", {28'h0, tgt}, {28'h0, in_two_gain_o});
        // Ramp with zero cross also set: steps of one code, no crossing.
        wr(0, 8'h08, 4'h1);
        wr(1, 8'h02, 4'h1);
        repeat (2) @(posedge clk_i);
        wr(0, 8'h38, 4'h1);
        wr(1, 8'h09, 4'h1);
        prev = in_one_gain_o;
        steps = 0;
        for (int k = 0; k < 20 * RAMP && prev !== 4'h9; k++) begin
            @(posedge clk_i);
            if (in_one_gain_o !== prev) begin
                check("ramp_step", {28'h0, prev + 4'h1},
                    {28'h0, in_one_gain_o});
                prev = in_one_gain_o;
                steps++;
            end
        end
        check("ramp_steps", 32'd7, steps);
        check_pins();
        // A second reset after traffic must restore every reset value.
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) shadow[i] = reset_val(i);
        check_pins();
        for (int i = 0; i < 8; i++) rd_chk(i);
        wrap_up();
    end
endmodule // test_mixer_amp_regs
`default_nettype wire
